// ---- rtl/dpl_pkg.sv ----
// Shared constants of the digital PLL reference and state control block.
// Assumes a 32-bit AXI4-Lite register map, one word per register.
package dpl_pkg;
  // ****************
  // Register map
  // ****************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIV = 8'h04;
  localparam logic [7:0] OFF_PRIO = 8'h08;
  localparam logic [7:0] OFF_NGAIN = 8'h0C;
  localparam logic [7:0] OFF_AGAIN = 8'h10;
  localparam logic [7:0] OFF_POFFS = 8'h14;
  localparam logic [7:0] OFF_WFREQ = 8'h18;
  localparam logic [7:0] OFF_LOCK = 8'h1C;
  localparam logic [7:0] OFF_AWHOLE = 8'h20;
  localparam logic [7:0] OFF_AFRAC = 8'h24;
  localparam logic [7:0] OFF_SLOPE = 8'h28;
  localparam logic [7:0] OFF_STAT = 8'h2C;
  localparam logic [7:0] OFF_FREQ = 8'h30;
  // ****************
  // Fields
  // ****************
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_MSEL = 1;
  localparam int CTRL_REV = 2;
  localparam int CTRL_HITLESS = 3;
  localparam int CTRL_OVR = 4;
  localparam int CTRL_FAILHOLD = 6;
  localparam int CTRL_DIFF = 7;
  localparam int CTRL_SYNTH = 8;
  localparam int PRIO_W = 4;
  localparam int GAIN_MULT = 0;
  localparam int GAIN_SHIFT = 8;
  localparam int GAIN_DMULT = 16;
  localparam int GAIN_DSHIFT = 24;
  localparam int LOCK_THR = 0;
  localparam int LOCK_TMR = 16;
  localparam int STAT_LOL = 16;
  localparam int STAT_LOL_LANE = 2;
  localparam logic [1:0] OVR_AUTO = 2'h0;
  localparam logic [1:0] OVR_FREE = 2'h1;
  localparam logic [1:0] OVR_HOLD = 2'h2;
  localparam logic [1:0] OVR_WFREQ = 2'h3;
  // ****************
  // Reset values and bus response codes
  // ****************
  localparam logic [31:0] CTRL_RST = 32'h0000_0045;
  localparam logic [31:0] DIV_RST = 32'h0000_0101;
  localparam logic [31:0] PRIO_RST = 32'h0000_0000;
  localparam logic [31:0] NGAIN_RST = 32'h0801_0401;
  localparam logic [31:0] AGAIN_RST = 32'h0601_0201;
  localparam logic [31:0] LOCK_RST = 32'h0100_0010;
  localparam logic [31:0] AWHOLE_RST = 32'h0000_00C8;
  localparam logic [31:0] SLOPE_RST = 32'h0000_FFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************
  // Datapath and timing
  // ****************
  localparam int FREQ_W = 28;
  localparam int FREQ_LSB_EXP = 40;
  localparam longint INT_LIMIT_PPM = 244;
  localparam logic signed [28:0] INT_LIMIT = 29'((INT_LIMIT_PPM * (64'h1 << FREQ_LSB_EXP)) / 1000000);
  localparam int SDM_FRAC_W = 27;
  localparam int SDM_SCALE_SHIFT = FREQ_LSB_EXP - SDM_FRAC_W;
  localparam longint CLK_HZ = 10000000;
  localparam longint TDC_MAX_HZ = 33000000;
  typedef enum logic [5:0] {
    ST_FREE = 6'h01,
    ST_ACQ = 6'h02,
    ST_NORM = 6'h04,
    ST_HOLD = 6'h08,
    ST_HITLESS = 6'h10,
    ST_WFREQ = 6'h20
  } dpl_state_t;
endpackage

// ---- rtl/dpl_ref_ctrl.sv ----
// Reference divide, selection, loop filter, lock detect and state control of a digital PLL.
// Assumes reference pins and monitor statuses are asynchronous; phase samples arrive on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module dpl_ref_ctrl #(
  parameter int DIV_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic refInputPositive,
  input wire logic refInputNegative,
  input wire logic [1:0] refQualOk,
  input wire logic startupDone,
  input wire logic [15:0] tdcPhase,
  input wire logic tdcPhaseValid,
  output logic [1:0] dividedRef,
  output logic lockPin,
  output logic [5:0] dpllState,
  output logic selectedRef,
  output logic [28:0] freqOffset,
  output logic [8:0] analogLoopRatio
);
  // ****************
  // Parameter check
  // ****************
  if (DIV_W < 2 || DIV_W > 16) begin : badDivW
    $error("DIV_W must be between 2 and 16");
  end

  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic bval;
    logic [1:0] bresp;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awHeld;
    logic wHeld;
    logic arrdy;
    logic rval;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] div;
    logic [31:0] prio;
    logic [31:0] ngain;
    logic [31:0] again;
    logic [31:0] poffs;
    logic [31:0] wfreq;
    logic [31:0] lockCfg;
    logic [31:0] awhole;
    logic [31:0] afrac;
    logic [31:0] slope;
    logic [1:0] ref1;
    logic [1:0] ref2;
    logic [1:0] refPrev;
    logic [1:0] qual1;
    logic [1:0] qual2;
    logic start1;
    logic start2;
    logic [1:0][DIV_W-1:0] divCnt;
    logic [1:0] divOut;
    dpl_pkg::dpl_state_t st;
    logic sel;
    logic lock;
    logic lol;
    logic [15:0] lockCnt;
    logic [16:0] hitOffs;
    logic [28:0] integ;
    logic [28:0] freq;
    logic [26:0] sdAcc;
    logic [8:0] ratio;
  } dpl_regs_t;

  dpl_regs_t q;
  dpl_regs_t d;

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic signed [28:0] scaleGain(input logic signed [16:0] ph, input logic [7:0] m,
                                                   input logic [4:0] sh);
    logic signed [25:0] p;
    logic signed [25:0] s;
    p = ph * $signed({1'b0, m});
    s = p >>> sh;
    return {{3{s[25]}}, s};
  endfunction

  function automatic logic signed [28:0] clampSym(input logic signed [29:0] v, input logic signed [28:0] lim);
    logic signed [29:0] limX;
    limX = {lim[28], lim};
    if (v > limX) begin
      return lim;
    end else if (v < -limX) begin
      return -lim;
    end
    return v[28:0];
  endfunction

  // ****************
  // Next state
  // ****************
  logic [1:0] qualV;
  logic bestRef;
  logic selN;
  logic refSwitch;
  logic selQual;
  logic lolClr;
  logic lockFell;
  logic hitlessEn;
  logic synthMode;
  logic [1:0] ovr;
  logic [31:0] gain;
  logic signed [16:0] phE;
  logic signed [28:0] prop;
  logic signed [28:0] dmp;
  logic signed [28:0] slopeLim;
  logic signed [28:0] wfExt;
  logic [15:0] absPh;
  logic signed [38:0] adjP;
  logic signed [29:0] tot;
  logic [26:0] step;
  logic [27:0] sdSum;
  logic [DIV_W-1:0] divN;

  always_comb begin
    d = q;
    lolClr = 1'b0;
    hitlessEn = q.ctrl[dpl_pkg::CTRL_HITLESS];
    synthMode = q.ctrl[dpl_pkg::CTRL_SYNTH];
    ovr = q.ctrl[dpl_pkg::CTRL_OVR +: 2];
    wfExt = {q.wfreq[dpl_pkg::FREQ_W-1], q.wfreq[dpl_pkg::FREQ_W-1:0]};
    // Write channel: address and data taken in either order
    if (q.awrdy && s_axi_awvalid) begin
      d.awAddr = s_axi_awaddr;
      d.awHeld = 1'b1;
      d.awrdy = 1'b0;
    end
    if (q.wrdy && s_axi_wvalid) begin
      d.wData = s_axi_wdata;
      d.wStrb = s_axi_wstrb;
      d.wHeld = 1'b1;
      d.wrdy = 1'b0;
    end
    if (q.awHeld && q.wHeld && !q.bval) begin
      d.bval = 1'b1;
      d.bresp = dpl_pkg::RESP_OKAY;
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      case (q.awAddr)
        dpl_pkg::OFF_CTRL: d.ctrl = mergeBytes(q.ctrl, q.wData, q.wStrb);
        dpl_pkg::OFF_DIV: d.div = mergeBytes(q.div, q.wData, q.wStrb);
        dpl_pkg::OFF_PRIO: d.prio = mergeBytes(q.prio, q.wData, q.wStrb);
        dpl_pkg::OFF_NGAIN: d.ngain = mergeBytes(q.ngain, q.wData, q.wStrb);
        dpl_pkg::OFF_AGAIN: d.again = mergeBytes(q.again, q.wData, q.wStrb);
        dpl_pkg::OFF_POFFS: d.poffs = mergeBytes(q.poffs, q.wData, q.wStrb);
        dpl_pkg::OFF_WFREQ: d.wfreq = mergeBytes(q.wfreq, q.wData, q.wStrb);
        dpl_pkg::OFF_LOCK: d.lockCfg = mergeBytes(q.lockCfg, q.wData, q.wStrb);
        dpl_pkg::OFF_AWHOLE: d.awhole = mergeBytes(q.awhole, q.wData, q.wStrb);
        dpl_pkg::OFF_AFRAC: d.afrac = mergeBytes(q.afrac, q.wData, q.wStrb);
        dpl_pkg::OFF_SLOPE: d.slope = mergeBytes(q.slope, q.wData, q.wStrb);
        dpl_pkg::OFF_STAT: lolClr = q.wStrb[dpl_pkg::STAT_LOL_LANE] && q.wData[dpl_pkg::STAT_LOL];
        dpl_pkg::OFF_FREQ: d.bresp = dpl_pkg::RESP_OKAY;
        default: d.bresp = dpl_pkg::RESP_SLVERR;
      endcase
    end
    if (q.bval && s_axi_bready) begin
      d.bval = 1'b0;
      d.awrdy = 1'b1;
      d.wrdy = 1'b1;
    end
    // Read channel
    if (q.arrdy && s_axi_arvalid) begin
      d.arrdy = 1'b0;
      d.rval = 1'b1;
      d.rresp = dpl_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dpl_pkg::OFF_CTRL: d.rdata = q.ctrl;
        dpl_pkg::OFF_DIV: d.rdata = q.div;
        dpl_pkg::OFF_PRIO: d.rdata = q.prio;
        dpl_pkg::OFF_NGAIN: d.rdata = q.ngain;
        dpl_pkg::OFF_AGAIN: d.rdata = q.again;
        dpl_pkg::OFF_POFFS: d.rdata = q.poffs;
        dpl_pkg::OFF_WFREQ: d.rdata = q.wfreq;
        dpl_pkg::OFF_LOCK: d.rdata = q.lockCfg;
        dpl_pkg::OFF_AWHOLE: d.rdata = q.awhole;
        dpl_pkg::OFF_AFRAC: d.rdata = q.afrac;
        dpl_pkg::OFF_SLOPE: d.rdata = q.slope;
        dpl_pkg::OFF_STAT: d.rdata = {15'h0000, q.lol, 4'h0, q.qual2, q.sel, q.lock, 2'h0, q.st};
        dpl_pkg::OFF_FREQ: d.rdata = {{3{q.freq[28]}}, q.freq};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = dpl_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (q.rval && s_axi_rready) begin
      d.rval = 1'b0;
      d.arrdy = 1'b1;
    end

    // ****************
    // Synchronisers and input dividers
    // ****************
    d.ref1 = {refInputNegative, refInputPositive};
    d.ref2 = q.ref1;
    d.refPrev = q.ref2;
    d.qual1 = refQualOk;
    d.qual2 = q.qual1;
    d.start1 = startupDone;
    d.start2 = q.start1;
    for (int i = 0; i < 2; i++) begin
      // Counting both edges makes the half period N input half periods, so any N keeps 50/50
      divN = q.div[DIV_W*i +: DIV_W];
      if (q.ref2[i] != q.refPrev[i]) begin
        if (q.divCnt[i] + 1'b1 >= divN) begin
          d.divCnt[i] = '0;
          d.divOut[i] = !q.divOut[i];
        end else begin
          d.divCnt[i] = q.divCnt[i] + 1'b1;
        end
      end
    end

    // ****************
    // Reference selection
    // ****************
    qualV[0] = q.qual2[0];
    qualV[1] = q.qual2[1] && !q.ctrl[dpl_pkg::CTRL_DIFF];
    bestRef = qualV[1] && (!qualV[0] ||
              q.prio[dpl_pkg::PRIO_W +: dpl_pkg::PRIO_W] < q.prio[0 +: dpl_pkg::PRIO_W]);
    if (!q.ctrl[dpl_pkg::CTRL_AUTO]) begin
      selN = q.ctrl[dpl_pkg::CTRL_MSEL] && !q.ctrl[dpl_pkg::CTRL_DIFF];
    end else if (!q.ctrl[dpl_pkg::CTRL_REV] && qualV[q.sel]) begin
      selN = q.sel;
    end else if (qualV != 2'h0) begin
      selN = bestRef;
    end else begin
      selN = q.sel;
    end
    d.sel = selN;
    refSwitch = selN != q.sel;
    selQual = qualV[selN];

    // ****************
    // State machine
    // ****************
    if (!q.start2 || synthMode) begin
      d.st = dpl_pkg::ST_FREE;
    end else if (ovr == dpl_pkg::OVR_FREE) begin
      d.st = dpl_pkg::ST_FREE;
    end else if (ovr == dpl_pkg::OVR_HOLD) begin
      d.st = dpl_pkg::ST_HOLD;
    end else if (ovr == dpl_pkg::OVR_WFREQ) begin
      d.st = dpl_pkg::ST_WFREQ;
    end else begin
      case (q.st)
        dpl_pkg::ST_FREE, dpl_pkg::ST_WFREQ: begin
          d.st = selQual ? dpl_pkg::ST_ACQ : dpl_pkg::ST_FREE;
        end
        dpl_pkg::ST_ACQ: begin
          if (!selQual) begin
            d.st = q.ctrl[dpl_pkg::CTRL_FAILHOLD] ? dpl_pkg::ST_HOLD : dpl_pkg::ST_FREE;
          end else if (refSwitch && hitlessEn) begin
            d.st = dpl_pkg::ST_HITLESS;
          end else if (q.lock) begin
            d.st = dpl_pkg::ST_NORM;
          end
        end
        dpl_pkg::ST_NORM: begin
          if (!selQual || refSwitch) begin
            d.st = dpl_pkg::ST_HOLD;
          end
        end
        dpl_pkg::ST_HOLD: begin
          if (selQual) begin
            d.st = hitlessEn ? dpl_pkg::ST_HITLESS : dpl_pkg::ST_ACQ;
          end
        end
        dpl_pkg::ST_HITLESS: begin
          if (!selQual) begin
            d.st = dpl_pkg::ST_HOLD;
          end else if (tdcPhaseValid) begin
            d.st = dpl_pkg::ST_ACQ;
          end
        end
        default: d.st = dpl_pkg::ST_FREE;
      endcase
    end

    // ****************
    // Hitless offset and loop filter
    // ****************
    if (!hitlessEn) begin
      d.hitOffs = 17'h00000;
    end else if (q.st == dpl_pkg::ST_HITLESS && tdcPhaseValid && selQual) begin
      d.hitOffs = {tdcPhase[15], tdcPhase};
    end
    if (hitlessEn) begin
      phE = $signed({tdcPhase[15], tdcPhase}) - $signed(q.hitOffs);
    end else begin
      phE = $signed({tdcPhase[15], tdcPhase}) + $signed({q.poffs[15], q.poffs[15:0]});
    end
    gain = (q.st == dpl_pkg::ST_NORM) ? q.ngain : q.again;
    prop = scaleGain(phE, gain[dpl_pkg::GAIN_MULT +: 8], gain[dpl_pkg::GAIN_SHIFT +: 5]);
    dmp = scaleGain(phE, gain[dpl_pkg::GAIN_DMULT +: 8], gain[dpl_pkg::GAIN_DSHIFT +: 5]);
    slopeLim = $signed({13'h0000, q.slope[15:0]});
    if (!hitlessEn) begin
      prop = clampSym({prop[28], prop}, slopeLim);
    end
    case (q.st)
      dpl_pkg::ST_ACQ, dpl_pkg::ST_NORM: begin
        if (tdcPhaseValid) begin
          d.integ = clampSym(30'($signed(q.integ)) + 30'(dmp), dpl_pkg::INT_LIMIT);
          d.freq = clampSym(30'($signed(d.integ)) + 30'(prop), dpl_pkg::INT_LIMIT);
        end
      end
      dpl_pkg::ST_HOLD, dpl_pkg::ST_HITLESS: begin
        d.freq = q.integ;
      end
      dpl_pkg::ST_WFREQ: begin
        d.integ = wfExt;
        d.freq = wfExt;
      end
      default: begin
        d.integ = 29'h0000_0000;
        d.freq = synthMode ? wfExt : 29'h0000_0000;
      end
    endcase

    // ****************
    // Lock detector
    // ****************
    absPh = phE[16] ? 16'(-phE) : phE[15:0];
    if (q.st != dpl_pkg::ST_ACQ && q.st != dpl_pkg::ST_NORM) begin
      d.lock = 1'b0;
      d.lockCnt = 16'h0000;
    end else if (tdcPhaseValid) begin
      if (absPh <= q.lockCfg[dpl_pkg::LOCK_THR +: 16]) begin
        if (q.lockCnt >= q.lockCfg[dpl_pkg::LOCK_TMR +: 16]) begin
          d.lock = 1'b1;
        end else begin
          d.lockCnt = q.lockCnt + 16'h0001;
        end
      end else begin
        d.lock = 1'b0;
        d.lockCnt = 16'h0000;
      end
    end
    lockFell = q.lock && !d.lock;
    d.lol = (q.lol && !lolClr) || lockFell;

    // ****************
    // Feedback sigma-delta
    // ****************
    // First order only; the divider tolerates one analog cycle of error
    adjP = $signed(q.freq) * $signed({1'b0, q.awhole[8:0]});
    tot = $signed({3'h0, q.afrac[26:0]}) + $signed({{4{adjP[38]}}, adjP[38:dpl_pkg::SDM_SCALE_SHIFT]});
    if (tot[29]) begin
      step = 27'h000_0000;
    end else if (tot[28:27] != 2'h0) begin
      step = 27'h7FF_FFFF;
    end else begin
      step = tot[26:0];
    end
    sdSum = {1'b0, q.sdAcc} + {1'b0, step};
    d.sdAcc = sdSum[26:0];
    d.ratio = q.awhole[8:0] + {8'h00, sdSum[27]};

    if (rst) begin
      d = '0;
      d.awrdy = 1'b1;
      d.wrdy = 1'b1;
      d.arrdy = 1'b1;
      d.ctrl = dpl_pkg::CTRL_RST;
      d.div = dpl_pkg::DIV_RST;
      d.prio = dpl_pkg::PRIO_RST;
      d.ngain = dpl_pkg::NGAIN_RST;
      d.again = dpl_pkg::AGAIN_RST;
      d.lockCfg = dpl_pkg::LOCK_RST;
      d.awhole = dpl_pkg::AWHOLE_RST;
      d.slope = dpl_pkg::SLOPE_RST;
      d.st = dpl_pkg::ST_FREE;
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  assign s_axi_awready = q.awrdy;
  assign s_axi_wready = q.wrdy;
  assign s_axi_bvalid = q.bval;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arrdy;
  assign s_axi_rvalid = q.rval;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign dividedRef = q.divOut;
  assign lockPin = q.lock;
  assign dpllState = q.st;
  assign selectedRef = q.sel;
  assign freqOffset = q.freq;
  assign analogLoopRatio = q.ratio;

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence acqThenNormS;
    (q.st == dpl_pkg::ST_ACQ) ##1 (q.st == dpl_pkg::ST_NORM);
  endsequence

  lol_sticky_a: assert property ($fell(q.lock) |-> q.lol) else $error("loss of lock not flagged");
  startup_free_a: assert property (!q.start2 |=> q.st == dpl_pkg::ST_FREE) else $error("not freerun");
  hold_freeze_a: assert property (q.st == dpl_pkg::ST_HOLD |=> $stable(q.integ)) else $error("hold moved");
  free_zero_a: assert property (q.st == dpl_pkg::ST_FREE |=> q.integ == 29'h0) else $error("integ set");
  integ_clamp_a: assert property ($signed(q.integ) <= dpl_pkg::INT_LIMIT
    && $signed(q.integ) >= -dpl_pkg::INT_LIMIT) else $error("integrator out of range");
  write_freq_a: assert property (q.st == dpl_pkg::ST_WFREQ |=> q.freq == $past(wfExt)) else $error("wf word");
  acq_lock_a: assert property (acqThenNormS |-> $past(q.lock)) else $error("normal without lock");
  nonrev_keep_a: assert property (q.ctrl[dpl_pkg::CTRL_AUTO] && !q.ctrl[dpl_pkg::CTRL_REV] && qualV[q.sel]
    |=> q.sel == $past(q.sel)) else $error("non-revertive switched");
  tie_break_a: assert property (q.ctrl[dpl_pkg::CTRL_AUTO] && qualV == 2'h3 && q.prio[7:4] == q.prio[3:0]
    && q.ctrl[dpl_pkg::CTRL_REV] |=> !q.sel) else $error("tie not reference zero");
  hitless_clear_a: assert property (!hitlessEn |=> q.hitOffs == 17'h0) else $error("offset kept");
endmodule
`default_nettype wire

// ---- verification/dpl_ref_src.sv ----
// Reference clock sources with their quality monitors.
// Assumes the bench sets the wanted quality of each reference.
`timescale 1ns/1ps
`default_nettype none
module dpl_ref_src #(
  parameter int HALF0 = 370,
  parameter int HALF1 = 530
) (
  input wire logic [1:0] qualSet,
  output logic refP,
  output logic refN,
  output logic [1:0] qual
);
  // Slower than half of sys_clk, so the synchronizer sees every edge
  initial begin
    refP = 1'b0;
    forever #HALF0 refP = ~refP;
  end
  initial begin
    refN = 1'b0;
    forever #HALF1 refN = ~refN;
  end
  // Status changes off the block clock, as a real monitor does
  // Continuous so the time-zero setting is never missed
  assign #37 qual = qualSet;
endmodule
`default_nettype wire

// ---- verification/dpll_reference_and_state_control_tb.sv ----
// Self-checking bench: register access, selection, lock and state control.
// Assumes the reference model drives the pins and quality statuses.
`timescale 1ns/1ps
`default_nettype none
module dpll_reference_and_state_control_tb;
  logic sys_clk, rst, startupDone, tdcPhaseValid, refP, refN, lockPin, selectedRef;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, refQualOk, qualSet, dividedRef;
  logic [15:0] tdcPhase;
  logic [5:0] dpllState;
  logic [28:0] freqOffset;
  logic [8:0] analogLoopRatio;
  int n_errors, check_count, cycles;
  int refEdges, lastEdges;
  logic [7:0] ra [4] = '{dpl_pkg::OFF_CTRL, dpl_pkg::OFF_DIV, dpl_pkg::OFF_NGAIN, dpl_pkg::OFF_LOCK};
  logic [31:0] rv [4] = '{dpl_pkg::CTRL_RST, dpl_pkg::DIV_RST, dpl_pkg::NGAIN_RST, dpl_pkg::LOCK_RST};

  dpl_ref_ctrl i_dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .refInputPositive(refP),
    .refInputNegative(refN), .refQualOk, .startupDone, .tdcPhase, .tdcPhaseValid, .dividedRef, .lockPin,
    .dpllState, .selectedRef, .freqOffset, .analogLoopRatio);
  dpl_ref_src i_src (.qualSet, .refP, .refN, .qual(refQualOk));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Reference zero edges between divided toggles; sync latency stays below one half period
  always @(refP) refEdges++;
  always @(dividedRef[0]) begin
    lastEdges = refEdges;
    refEdges = 0;
  end

  // ****************
  // Tasks
  // ****************
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(er));
    @(posedge sys_clk);
  endtask

  task automatic axiRd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic waitSt(input logic [5:0] e);
    int t;
    t = 0;
    while (dpllState !== e && t < 100) begin
      @(posedge sys_clk);
      t++;
    end
    check("state", 32'(dpllState), 32'(e));
  endtask

  task automatic summarize;
    $display("Errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  // ****************
  // Sequence
  // ****************
  initial begin
    {rst, s_axi_wstrb} = 5'h1F;
    {startupDone, tdcPhaseValid, tdcPhase, qualSet} = 20'h00003;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (ra[i]) begin
      axiRd(ra[i]);
      check("reset value", rd, rv[i]);
    end
    axiRd(8'h3C);
    check("unmapped rdata", rd, 32'h0);
    check("unmapped rresp", 32'(rr), 32'(dpl_pkg::RESP_SLVERR));
    axiWr(8'h40, 32'hFFFF_FFFF, dpl_pkg::RESP_SLVERR);
    axiWr(dpl_pkg::OFF_CTRL, 32'h0000_0061, dpl_pkg::RESP_OKAY);
    repeat (10) @(posedge sys_clk);
    waitSt(dpl_pkg::ST_FREE);
    check("freq", 32'(freqOffset), 32'h0);
    axiWr(dpl_pkg::OFF_AFRAC, 32'h0400_0000, dpl_pkg::RESP_OKAY);
    axiWr(dpl_pkg::OFF_DIV, 32'h0000_0103, dpl_pkg::RESP_OKAY);
    repeat (50) @(posedge sys_clk);
    rd = 32'(analogLoopRatio);
    @(posedge sys_clk);
    check("fraction", rd + 32'(analogLoopRatio), 32'h0000_0191);
    check("divide", 32'(lastEdges), 32'h0000_0003);
    axiWr(dpl_pkg::OFF_CTRL, 32'h0000_0041, dpl_pkg::RESP_OKAY);
    axiWr(dpl_pkg::OFF_LOCK, 32'h0002_0100, dpl_pkg::RESP_OKAY);
    startupDone <= 1'b1;
    waitSt(dpl_pkg::ST_ACQ);
    check("sel", 32'(selectedRef), 32'h0);
    repeat (6) begin
      tdcPhase <= 16'h0080;
      tdcPhaseValid <= 1'b1;
      @(posedge sys_clk);
      tdcPhaseValid <= 1'b0;
      @(posedge sys_clk);
    end
    waitSt(dpl_pkg::ST_NORM);
    check("lock pin", 32'(lockPin), 32'h1);
    axiRd(dpl_pkg::OFF_STAT);
    check("lock status", 32'(rd[8]), 32'h1);
    qualSet <= 2'b10;
    waitSt(dpl_pkg::ST_HOLD);
    waitSt(dpl_pkg::ST_ACQ);
    check("sel", 32'(selectedRef), 32'h1);
    check("lock pin", 32'(lockPin), 32'h0);
    check("hold freq", 32'(freqOffset), 32'h0000_0006);
    axiRd(dpl_pkg::OFF_STAT);
    check("lol", 32'(rd[16]), 32'h1);
    axiWr(dpl_pkg::OFF_STAT, 32'h0001_0000, dpl_pkg::RESP_OKAY);
    axiRd(dpl_pkg::OFF_STAT);
    check("lol", 32'(rd[16]), 32'h0);
    qualSet <= 2'b11;
    repeat (20) @(posedge sys_clk);
    check("sel", 32'(selectedRef), 32'h1);
    axiWr(dpl_pkg::OFF_CTRL, 32'h0000_0045, dpl_pkg::RESP_OKAY);
    repeat (10) @(posedge sys_clk);
    check("sel", 32'(selectedRef), 32'h0);
    axiWr(dpl_pkg::OFF_CTRL, 32'h0000_0042, dpl_pkg::RESP_OKAY);
    repeat (10) @(posedge sys_clk);
    check("sel", 32'(selectedRef), 32'h1);
    axiWr(dpl_pkg::OFF_CTRL, 32'h0000_0049, dpl_pkg::RESP_OKAY);
    qualSet <= 2'b00;
    waitSt(dpl_pkg::ST_HOLD);
    qualSet <= 2'b01;
    waitSt(dpl_pkg::ST_HITLESS);
    tdcPhaseValid <= 1'b1;
    @(posedge sys_clk);
    tdcPhaseValid <= 1'b0;
    waitSt(dpl_pkg::ST_ACQ);
    axiWr(dpl_pkg::OFF_WFREQ, 32'h0000_0123, dpl_pkg::RESP_OKAY);
    axiWr(dpl_pkg::OFF_CTRL, 32'h0000_0051, dpl_pkg::RESP_OKAY);
    waitSt(dpl_pkg::ST_FREE);
    @(posedge sys_clk);
    check("freq", 32'(freqOffset), 32'h0);
    axiWr(dpl_pkg::OFF_CTRL, 32'h0000_0061, dpl_pkg::RESP_OKAY);
    waitSt(dpl_pkg::ST_HOLD);
    axiWr(dpl_pkg::OFF_CTRL, 32'h0000_0071, dpl_pkg::RESP_OKAY);
    waitSt(dpl_pkg::ST_WFREQ);
    @(posedge sys_clk);
    check("freq", 32'(freqOffset), 32'h0000_0123);
    axiWr(dpl_pkg::OFF_CTRL, 32'h0000_0141, dpl_pkg::RESP_OKAY);
    waitSt(dpl_pkg::ST_FREE);
    @(posedge sys_clk);
    check("freq", 32'(freqOffset), 32'h0000_0123);
    summarize();
  end
endmodule
`default_nettype wire
